// ===== rtl/port_regs_consts.svh
// constants of the port test and debug register bank
// assumes byte addresses on a 32-bit wishbone bus
`ifndef PORT_REGS_CONSTS_SVH
`define PORT_REGS_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_PHY_TEST 12'h320
`define OFS_HOLD 12'h324
`define OFS_IND0 12'h328
`define OFS_IND1 12'h32C
`define OFS_FSM_STAT 12'h33C
`define OFS_LL_STAT 12'h340
`define OFS_TL_CFG 12'h344
`define OFS_PROBE_CTRL 12'h348
`define OFS_PROBE_DATA 12'h34C

// ----------------------------------------
// writable bit masks, everything else reads zero
// ----------------------------------------
`define MASK_PHY_TEST 32'h007F_7F7F
`define MASK_HOLD 32'h0007_0707
`define MASK_IND0 32'h0000_01FF
`define MASK_IND1 32'hFFFF_FFFF
`define MASK_TL_CFG 32'h0000_00FF
`define MASK_PROBE_CTRL 32'h0000_01FF

// ----------------------------------------
// field positions
// ----------------------------------------
`define POS_TRAIN_DIS 0
`define POS_QUIET 8
`define POS_PAT_RATE 16
`define PHY_PORT_STRIDE 8
`define POS_ADAPT_ACK 4
`define POS_FIX_DET_DIS 5

// ----------------------------------------
// reset values and the training probe group code
// ----------------------------------------
`define RST_FSM_STAT 8'h04
`define RST_LL_STAT 16'h0004
`define RST_TL_CFG 8'h03
`define GROUP_TRAINING 5'h00

`endif

// ===== rtl/port_regs_pkg.sv
// types shared by the port test and debug register bank
// assumes the constants header is compiled alongside
package port_regs_pkg;

  // one port's physical-layer test controls, bit 6 first
  typedef struct packed {
    logic compliance_sel;
    logic emphasis_ctrl;
    logic speed_ctrl;
    logic loop_state_in;
    logic compliance_rx;
    logic scrambler_off;
    logic loop_request;
  } phy_test_port_type;

  // per-port link training steering, bit n for port n
  typedef struct packed {
    logic [2:0] pattern_rate;
    logic [2:0] quiet_hold;
    logic [2:0] training_disable;
  } port_ctrl_type;

  // probe selection handed to the capture block
  typedef struct packed {
    logic start;
    logic [2:0] port;
    logic [4:0] group;
  } probe_sel_type;

endpackage

// ===== rtl/probe_capture.sv
// probe selector and capture register
// assumes probe words come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "port_regs_consts.svh"

module probe_capture
  import port_regs_pkg::*;
#(
  parameter int NUM_PORTS = 3,
  parameter int PROBE_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // selection from the control register
  input wire probe_sel_type sel,
  // training group words, one per port
  input wire logic [NUM_PORTS-1:0][PROBE_W-1:0] fsm_probe,
  // captured word
  output logic [PROBE_W-1:0] data
);

  // ----------------------------------------
  // selection
  // ----------------------------------------
  logic [PROBE_W-1:0] picked; // word chosen by group and port

  // only the training group is defined; others give zero
  always_comb begin
    picked = '0;
    if (sel.group == `GROUP_TRAINING) begin
      if (32'(sel.port) < NUM_PORTS) begin
        picked = fsm_probe[sel.port];
      end
    end
  end

  // ----------------------------------------
  // capture
  // ----------------------------------------
  // follows the selection while start is set, freezes otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data <= '0;
    end else if (sel.start) begin
      data <= picked;
    end
  end

  capture_track_a: assert property (@(posedge clk) disable iff (!nrst)
    sel.start |=> data == $past(picked))
    else $error("probe data did not follow selection");
  capture_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    !sel.start |=> $stable(data))
    else $error("probe data moved without start");
  group_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (sel.start && sel.group != 5'h00) |=> data == '0)
    else $error("undefined group gave data");
  capture_run_c: cover property (@(posedge clk) disable iff (!nrst)
    sel.start ##1 !sel.start);

endmodule
`default_nettype wire

// ===== rtl/port_phy_test_debug_regs.sv
// port test and debug register bank, wishbone slave
// assumes a classic wishbone master on clk and
// same-clock sources for load strobes and probe words
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "port_regs_consts.svh"

module port_phy_test_debug_regs
  import port_regs_pkg::*;
#(
  parameter int NUM_PORTS = 3,
  parameter int PROBE_W = 32,
  parameter bit IS_UPSTREAM = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // configuration load of read-only defaults
  input wire logic cfg_load,
  input wire logic [7:0] cfg_fsm_status,
  input wire logic [15:0] cfg_ll_status,
  // per-port test controls
  output phy_test_port_type [NUM_PORTS-1:0] phy_test,
  output port_ctrl_type port_ctrl,
  // indicator and transaction layer settings
  output logic [7:0] indicator_field_a,
  output logic indicator_field_b,
  output logic [31:0] indicator_fields_c,
  output logic [7:0] transaction_layer_setting,
  // decoded link layer bits
  output logic adaptive_ack_policy,
  output logic fixed_detect_disable,
  // probe sources
  input wire logic [NUM_PORTS-1:0][PROBE_W-1:0] fsm_probe
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // the field layout is built for three ports and a word probe
  if (NUM_PORTS != 3) begin : g_bad_ports
    $error("NUM_PORTS must be 3");
  end
  if (PROBE_W != 32) begin : g_bad_width
    $error("PROBE_W must be 32");
  end

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic take; // request accepted this edge
  logic wr; // accepted write
  logic rd; // accepted read
  logic [31:0] bytes_on; // byte enables spread to bits

  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = take & wb_we_i;
  assign rd = take & ~wb_we_i;

  // one enable bit per data bit
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign bytes_on[b*8 +: 8] = {8{wb_sel_i[b]}};
  end

  // merge write data into a register under mask and lanes
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] mask
  );
    logic [31:0] en;
    en = bytes_on & mask;
    merge = (old & ~en) | (wb_dat_i & en);
  endfunction

  // ----------------------------------------
  // acknowledge
  // ----------------------------------------
  // one wait state, then a single-cycle ack; the ack term
  // in take stops a held request from being taken twice
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= take;
    end
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  logic [31:0] phy_reg; // test controls, all ports
  logic [31:0] hold_reg; // disable, quiet, pattern rate
  logic [31:0] ind0_reg; // indicator word 0
  logic [31:0] ind1_reg; // indicator word 1
  logic [31:0] tl_reg; // transaction layer setting
  logic [31:0] probe_reg; // probe control

  // test controls; reserved bits stay zero via the mask
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phy_reg <= 32'h0000_0000;
    end else if (wr && wb_adr_i == `OFS_PHY_TEST) begin
      phy_reg <= merge(phy_reg, `MASK_PHY_TEST);
    end
  end

  // training disable, quiet hold and pattern rate
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_reg <= 32'h0000_0000;
    end else if (wr && wb_adr_i == `OFS_HOLD) begin
      hold_reg <= merge(hold_reg, `MASK_HOLD);
    end
  end

  // indicator words only steer outside logic
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ind0_reg <= 32'h0000_0000;
      ind1_reg <= 32'h0000_0000;
    end else if (wr && wb_adr_i == `OFS_IND0) begin
      ind0_reg <= merge(ind0_reg, `MASK_IND0);
    end else if (wr && wb_adr_i == `OFS_IND1) begin
      ind1_reg <= merge(ind1_reg, `MASK_IND1);
    end
  end

  // transaction layer setting, resets to its default
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tl_reg <= {24'h00_0000, `RST_TL_CFG};
    end else if (wr && wb_adr_i == `OFS_TL_CFG) begin
      tl_reg <= merge(tl_reg, `MASK_TL_CFG);
    end
  end

  // probe control; a downstream instance keeps it at zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      probe_reg <= 32'h0000_0000;
    end else if (IS_UPSTREAM && wr && wb_adr_i == `OFS_PROBE_CTRL) begin
      probe_reg <= merge(probe_reg, `MASK_PROBE_CTRL);
    end
  end

  // ----------------------------------------
  // read-only status, loadable defaults
  // ----------------------------------------
  logic [7:0] fsm_stat; // link fsm status byte
  logic [15:0] ll_stat; // link layer status word

  // software cannot write these; only a configuration load
  // replaces the reset default
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fsm_stat <= `RST_FSM_STAT;
      ll_stat <= `RST_LL_STAT;
    end else if (cfg_load) begin
      fsm_stat <= cfg_fsm_status;
      ll_stat <= cfg_ll_status;
    end
  end

  // ----------------------------------------
  // probe capture
  // ----------------------------------------
  probe_sel_type probe_sel; // fields of the control word
  logic [PROBE_W-1:0] probe_data; // captured word

  assign probe_sel = probe_reg[8:0];

  probe_capture #(
    .NUM_PORTS(NUM_PORTS),
    .PROBE_W(PROBE_W)
  ) probe_capture_i (
    .clk(clk),
    .nrst(nrst),
    .sel(probe_sel),
    .fsm_probe(fsm_probe),
    .data(probe_data)
  );

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [31:0] next_rdata; // word for the addressed register

  // unmapped addresses, and the probe pair on a downstream
  // instance, read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `OFS_PHY_TEST: next_rdata = phy_reg;
      `OFS_HOLD: next_rdata = hold_reg;
      `OFS_IND0: next_rdata = ind0_reg;
      `OFS_IND1: next_rdata = ind1_reg;
      `OFS_FSM_STAT: next_rdata = {24'h00_0000, fsm_stat};
      `OFS_LL_STAT: next_rdata = {16'h0000, ll_stat};
      `OFS_TL_CFG: next_rdata = tl_reg;
      `OFS_PROBE_CTRL: begin
        if (IS_UPSTREAM) begin
          next_rdata = probe_reg;
        end
      end
      `OFS_PROBE_DATA: begin
        if (IS_UPSTREAM) begin
          next_rdata = probe_data;
        end
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read data is latched with the ack and held until the
  // next read, so it stands steady while ack is high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= next_rdata;
    end
  end

  // ----------------------------------------
  // outputs to the port logic
  // ----------------------------------------
  // each port's seven controls sit in its own byte
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign phy_test[p] = phy_reg[p*`PHY_PORT_STRIDE +: 7];
  end

  assign port_ctrl.training_disable = hold_reg[`POS_TRAIN_DIS +: 3];
  assign port_ctrl.quiet_hold = hold_reg[`POS_QUIET +: 3];
  assign port_ctrl.pattern_rate = hold_reg[`POS_PAT_RATE +: 3];
  assign indicator_field_a = ind0_reg[7:0];
  assign indicator_field_b = ind0_reg[8];
  assign indicator_fields_c = ind1_reg;
  assign transaction_layer_setting = tl_reg[7:0];
  assign adaptive_ack_policy = ll_stat[`POS_ADAPT_ACK];
  assign fixed_detect_disable = ll_stat[`POS_FIX_DET_DIS];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  train_disable_a: assert property (
    (wr && wb_adr_i == `OFS_HOLD && wb_sel_i[0])
    |=> port_ctrl.training_disable == $past(wb_dat_i[2:0]))
    else $error("training disable not written");
  quiet_hold_a: assert property (
    (wr && wb_adr_i == `OFS_HOLD && wb_sel_i[1])
    |=> port_ctrl.quiet_hold == $past(wb_dat_i[10:8]))
    else $error("quiet hold not written");
  phy_test_a: assert property (
    (wr && wb_adr_i == `OFS_PHY_TEST && wb_sel_i[2])
    |=> phy_test[2] == $past(wb_dat_i[22:16]))
    else $error("port 2 test controls not written");
  pattern_rate_a: assert property (
    (wr && wb_adr_i == `OFS_HOLD && !wb_sel_i[2])
    |=> $stable(port_ctrl.pattern_rate))
    else $error("pattern rate changed without its lane");
  fsm_load_a: assert property (
    (cfg_load ##1 !cfg_load ##1 !cfg_load ##1 (rd && wb_adr_i == `OFS_FSM_STAT && !cfg_load))
    |=> wb_dat_o == {24'h00_0000, $past(cfg_fsm_status, 4)})
    else $error("loaded fsm status not read back");
  ll_bits_a: assert property (
    cfg_load |=> adaptive_ack_policy == $past(cfg_ll_status[4])
      && fixed_detect_disable == $past(cfg_ll_status[5]))
    else $error("link layer bits not decoded");
  probe_gate_a: assert property (
    (!IS_UPSTREAM && rd && wb_adr_i == `OFS_PROBE_CTRL) |=> wb_dat_o == 32'h0)
    else $error("downstream probe control visible");
  reserved_zero_a: assert property (
    (rd && wb_adr_i == `OFS_HOLD) |=> (wb_dat_o & ~`MASK_HOLD) == 32'h0)
    else $error("reserved bits read nonzero");
  ack_single_a: assert property (
    take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse");

  write_hold_c: cover property (wr && wb_adr_i == `OFS_HOLD);
  read_probe_c: cover property (rd && wb_adr_i == `OFS_PROBE_DATA);
  cfg_load_c: cover property (cfg_load);

endmodule
`default_nettype wire

// ===== verif/port_phy_test_debug_regs_test.sv
// self-checking bench for the port test and debug register bank
// assumes the package and constants header are compiled before this file
`timescale 1ns/1ps
`default_nettype none

module test_port_phy_test_debug_regs;
  import port_regs_pkg::*;

  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0; // active low, held low at time zero
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic cfg_load = 1'b0;
  logic [7:0] cfg_fsm = 8'h00;
  logic [15:0] cfg_ll = 16'h0000;
  logic [2:0][31:0] fsm_probe = {32'hC2C2_0002, 32'hB1B1_0001, 32'hA0A0_0000};
  logic [31:0] dat_o, ds_dat, rd, ds_rd;
  logic ack;
  phy_test_port_type [2:0] phy_test;
  port_ctrl_type port_ctrl;
  logic [7:0] ind_a, tl_set;
  logic ind_b, adapt, fixdis;
  logic [31:0] ind_c;
  logic [15:0] ll_tab [3] = '{16'hFF30, 16'h0010, 16'h0020}; // load values
  int err_count = 0;
  int n_compared = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  // ----------------------------------------
  // designs: upstream under test, downstream shares the bus inputs
  // ----------------------------------------
  // upstream instance keeps the default parameters
  port_phy_test_debug_regs port_phy_test_debug_regs_i (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .cfg_load(cfg_load),
    .cfg_fsm_status(cfg_fsm), .cfg_ll_status(cfg_ll), .phy_test(phy_test), .port_ctrl(port_ctrl),
    .indicator_field_a(ind_a), .indicator_field_b(ind_b), .indicator_fields_c(ind_c),
    .transaction_layer_setting(tl_set), .adaptive_ack_policy(adapt),
    .fixed_detect_disable(fixdis), .fsm_probe(fsm_probe));
  // downstream copy takes the same writes except probe control, its ack follows the same timing
  port_phy_test_debug_regs #(.IS_UPSTREAM(1'b0)) port_phy_test_debug_regs_ds_i (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(ds_dat), .wb_ack_o(), .cfg_load(cfg_load),
    .cfg_fsm_status(cfg_fsm), .cfg_ll_status(cfg_ll), .phy_test(), .port_ctrl(),
    .indicator_field_a(), .indicator_field_b(), .indicator_fields_c(),
    .transaction_layer_setting(), .adaptive_ack_policy(), .fixed_detect_disable(),
    .fsm_probe(fsm_probe));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    check("ack", 32'h1, {31'h0, ack});
    rd = dat_o;
    ds_rd = ds_dat;
    // release, then leave the bus idle so spacing stays legal
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, 4'hF, d);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 4'hF, 32'h0);
    check(what, exp, rd);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    rd_chk("phy test rst", 12'h320, 32'h0);
    rd_chk("hold rst", 12'h324, 32'h0);
    rd_chk("ind0 rst", 12'h328, 32'h0);
    rd_chk("ind1 rst", 12'h32C, 32'h0);
    rd_chk("fsm stat rst", 12'h33C, 32'h0000_0004);
    rd_chk("ll stat rst", 12'h340, 32'h0000_0004);
    rd_chk("tl cfg rst", 12'h344, 32'h0000_0003);
    rd_chk("probe ctrl rst", 12'h348, 32'h0);
    check("tl out rst", 32'h3, {24'h0, tl_set});
  endtask

  // walking one over every test control of every port
  task automatic t_phy_test();
    wr(12'h320, 32'hFFFF_FFFF);
    rd_chk("phy test mask", 12'h320, 32'h007F_7F7F);
    for (int p = 0; p < 3; p++) begin
      for (int b = 0; b < 7; b++) begin
        wr(12'h320, 32'h1 << (8 * p + b));
        check("phy test out", 32'h1 << (7 * p + b), {11'h0, phy_test});
      end
    end
    wr(12'h320, 32'h0);
    xfer(1'b1, 12'h320, 4'h2, 32'hFFFF_FFFF); // only lane 1 enabled
    rd_chk("phy test lane", 12'h320, 32'h0000_7F00);
  endtask

  // each of the three per-port fields, each port alone
  task automatic t_hold();
    wr(12'h324, 32'hFFFF_FFFF);
    rd_chk("hold mask", 12'h324, 32'h0007_0707);
    for (int f = 0; f < 3; f++) begin
      for (int p = 0; p < 3; p++) begin
        wr(12'h324, 32'h1 << (8 * f + p));
        check("port ctrl", 32'h1 << (3 * f + p), {23'h0, port_ctrl});
      end
    end
    // lanes 0 and 1 only: pattern rate bit 18 must survive
    xfer(1'b1, 12'h324, 4'h3, 32'hFFFF_FFFF);
    rd_chk("hold lane", 12'h324, 32'h0004_0707);
  endtask

  // read-only words ignore writes and take the loaded defaults
  task automatic t_ro_load();
    wr(12'h33C, 32'hFFFF_FFFF);
    wr(12'h340, 32'hFFFF_FFFF);
    rd_chk("fsm stat ro", 12'h33C, 32'h0000_0004);
    rd_chk("ll stat ro", 12'h340, 32'h0000_0004);
    for (int i = 0; i < 3; i++) begin
      cfg_load <= 1'b1;
      cfg_fsm <= 8'hA5 ^ 8'(i);
      cfg_ll <= ll_tab[i];
      @(posedge clk);
      cfg_load <= 1'b0;
      @(posedge clk);
      rd_chk("fsm stat load", 12'h33C, {24'h0, 8'hA5 ^ 8'(i)});
      rd_chk("ll stat load", 12'h340, {16'h0, ll_tab[i]});
      check("adaptive ack", {31'h0, ll_tab[i][4]}, {31'h0, adapt});
      check("detect disable", {31'h0, ll_tab[i][5]}, {31'h0, fixdis});
    end
  endtask

  task automatic t_misc();
    wr(12'h328, 32'hFFFF_FFFF);
    rd_chk("ind0 mask", 12'h328, 32'h0000_01FF);
    check("ind a b", 32'h1FF, {23'h0, ind_b, ind_a});
    wr(12'h32C, 32'hA5C3_0F96);
    rd_chk("ind1", 12'h32C, 32'hA5C3_0F96);
    check("ind c", 32'hA5C3_0F96, ind_c);
    wr(12'h344, 32'hFFFF_FF5A);
    rd_chk("tl cfg mask", 12'h344, 32'h0000_005A);
    wr(12'h350, 32'hFFFF_FFFF);
    rd_chk("unmapped", 12'h350, 32'h0);
    rd_chk("gap", 12'h330, 32'h0);
  endtask

  // capture per port, freeze on stop, refuse other groups and ports
  task automatic t_probe();
    for (int p = 0; p < 3; p++) begin
      wr(12'h348, 32'h100 | (p << 5));
      rd_chk("probe ctrl", 12'h348, 32'h100 | (p << 5));
      check("downstream ctrl", 32'h0, ds_rd);
      rd_chk("probe data", 12'h34C, fsm_probe[p]);
      check("downstream data", 32'h0, ds_rd);
    end
    wr(12'h348, 32'h040);
    fsm_probe <= {32'h0D0D_D0D0, 32'h0E0E_E0E0, 32'h0F0F_F0F0};
    rd_chk("probe frozen", 12'h34C, 32'hC2C2_0002);
    wr(12'h348, 32'h101);
    rd_chk("probe group", 12'h34C, 32'h0);
    wr(12'h348, 32'h160);
    rd_chk("probe port", 12'h34C, 32'h0);
    wr(12'h348, 32'hFFFF_FE20);
    rd_chk("probe ctrl mask", 12'h348, 32'h0000_0020);
  endtask

  // ----------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // whole run is a few hundred cycles; this bound means a hang
  initial begin
    #100us;
    err_count++;
    $display("[FAIL] run expected done seen hang");
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset_values();
    t_phy_test();
    t_hold();
    t_ro_load();
    t_misc();
    t_probe();
    tally_and_finish();
  end

endmodule

`default_nettype wire
